// File: src/phy_link_status_regs.sv
// phy link status, link state and prbs seed registers of one switch port
// assumes the phy training logic and the configuration requester share mclk
`timescale 1ns/1ps
module phy_link_status_regs (
  input  wire logic                          mclk,
  input  wire logic                          rst,
  input  wire logic                          soft_rst,
  input  wire phy_link_pkg::cfg_req_t        cfg_req,
  output phy_link_pkg::cfg_cpl_t             cfg_cpl,
  input  wire logic [4:0]                    training_state_code,
  input  wire logic                          partner_upconfig_capable,
  input  wire logic                          retrain_request,
  input  wire phy_link_pkg::width_result_t   width_reconfig_result,
  input  wire logic                          prbs_step,
  output logic                               full_retrain_trigger,
  output logic [15:0]                        prbs_value,
  output logic [15:0]                        prbs_seed
);
  import phy_link_pkg::*;

  // ****************************************
  // request decode
  // ****************************************

  logic hit_status;
  logic hit_state;
  logic hit_seed;
  logic wr_state;
  logic wr_seed;

  // only whole-word aligned offsets are decoded, others answer zero
  always_comb begin
    hit_status = (cfg_req.addr == OFS_LINK_STATUS);
    hit_state  = (cfg_req.addr == OFS_LINK_STATE);
    hit_seed   = (cfg_req.addr == OFS_PRBS_SEED);
    wr_state   = cfg_req.valid && cfg_req.write && hit_state;
    wr_seed    = cfg_req.valid && cfg_req.write && hit_seed;
  end

  // ****************************************
  // training state and partner capability
  // ****************************************

  logic [4:0] state_code_r;
  logic [4:0] state_code_nxt;
  logic       upcfg_r;
  logic       upcfg_nxt;

  // the phy codes arrive already in the listed encoding, so they are stored as is
  always_comb begin
    state_code_nxt = training_state_code;
    upcfg_nxt      = partner_upconfig_capable;
    if (soft_rst) begin
      state_code_nxt = STATE_RESET;
      upcfg_nxt      = 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_code_r <= STATE_RESET;
      upcfg_r      <= 1'b0;
    end else begin
      state_code_r <= state_code_nxt;
      upcfg_r      <= upcfg_nxt;
    end
  end

  // ****************************************
  // width reconfiguration outcome
  // ****************************************

  logic [1:0] result_r;
  logic [1:0] result_nxt;

  // a new retrain request clears to idle; an outcome in the same cycle wins
  always_comb begin
    result_nxt = result_r;
    if (retrain_request) begin
      result_nxt = RESULT_IDLE;
    end
    if (width_reconfig_result.valid) begin
      result_nxt = width_reconfig_result.code;
    end
    if (soft_rst) begin
      result_nxt = RESULT_IDLE;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      result_r <= RESULT_IDLE;
    end else begin
      result_r <= result_nxt;
    end
  end

  // ****************************************
  // full retrain sequencer
  // ****************************************

  retrain_state_t rt_state_r;
  retrain_state_t rt_state_nxt;
  logic           trigger_r;
  logic           trigger_nxt;
  logic           retrain_wr;

  // a second trigger while one is pending is absorbed into it
  always_comb begin
    retrain_wr   = wr_state && cfg_req.byte_en[3] && cfg_req.wdata[RETRAIN_BIT];
    rt_state_nxt = rt_state_r;
    trigger_nxt  = 1'b0;
    unique case (rt_state_r)
      RT_IDLE: begin
        if (retrain_wr) begin
          rt_state_nxt = RT_CPL;
        end
      end
      RT_CPL: begin
        // completion leaves in this cycle, the trigger follows it
        rt_state_nxt = RT_FIRE;
        trigger_nxt  = 1'b1;
      end
      RT_FIRE: begin
        rt_state_nxt = RT_IDLE;
      end
      default: begin
        rt_state_nxt = RT_IDLE;
      end
    endcase
    if (soft_rst) begin
      rt_state_nxt = RT_IDLE;
      trigger_nxt  = 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rt_state_r <= RT_IDLE;
      trigger_r  <= 1'b0;
    end else begin
      rt_state_r <= rt_state_nxt;
      trigger_r  <= trigger_nxt;
    end
  end

  assign full_retrain_trigger = trigger_r;

  // ****************************************
  // prbs seed, sticky across soft reset
  // ****************************************

  logic [15:0] seed_r;
  logic [15:0] seed_nxt;
  logic        seed_load_r;
  logic        seed_load_nxt;

  // byte lanes 0 and 1 hold the seed; upper lanes are reserved
  always_comb begin
    seed_nxt = seed_r;
    if (wr_seed && cfg_req.byte_en[0]) begin
      seed_nxt[7:0] = cfg_req.wdata[SEED_LSB +: 8];
    end
    if (wr_seed && cfg_req.byte_en[1]) begin
      seed_nxt[15:8] = cfg_req.wdata[SEED_LSB + 8 +: 8];
    end
    // reload only on a real change, so rewriting the same seed keeps the sequence
    seed_load_nxt = (seed_nxt != seed_r);
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      seed_r      <= SEED_RESET;
      seed_load_r <= 1'b0;
    end else begin
      seed_r      <= seed_nxt;
      seed_load_r <= seed_load_nxt;
    end
  end

  assign prbs_seed = seed_r;

  prbs_counter u_prbs (
    .mclk  (mclk),
    .rst   (rst),
    .load  (seed_load_r),
    .seed  (seed_r),
    .step  (prbs_step),
    .value (prbs_value)
  );

  // ****************************************
  // read data and completion
  // ****************************************

  logic [31:0] rdata_mux;
  cfg_cpl_t    cpl_r;
  cfg_cpl_t    cpl_nxt;

  // reserved bits and unmapped offsets read as zero
  always_comb begin
    rdata_mux = 32'h0000_0000;
    if (hit_status) begin
      rdata_mux[RESULT_LSB +: 2] = result_r;
      rdata_mux[UPCFG_BIT]       = upcfg_r;
    end
    if (hit_state) begin
      rdata_mux[STATE_LSB +: 5] = state_code_r;
      rdata_mux[RETRAIN_BIT]    = 1'b0;
    end
    if (hit_seed) begin
      rdata_mux[SEED_LSB +: 16] = seed_r;
    end
  end

  // every request, read or write, gets one completion the next cycle
  always_comb begin
    cpl_nxt.valid = cfg_req.valid;
    cpl_nxt.rdata = 32'h0000_0000;
    if (cfg_req.valid && !cfg_req.write) begin
      cpl_nxt.rdata = rdata_mux;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cpl_r <= '0;
    end else begin
      cpl_r <= cpl_nxt;
    end
  end

  assign cfg_cpl = cpl_r;

endmodule

// File: common/phy_link_pkg.sv
// constants, field layouts and carriers for the phy link status register bank
// assumes a single core clock and a configuration request port in the same domain
//
// What this block does
// - a two-bit read-only field reports a width change outcome: 0 idle, 1 ok, 2 short, 3 failed.
// - a read-only bit mirrors whether the link partner can upconfigure the link width.
// - a five-bit read-only field at the low bits shows the training state, zero after reset.
// - training states use the listed codes, for example detect quiet 2 and L0 0x14.
// - writing one to bit 31 of the link state register starts a full retrain into Detect.
// - the full retrain bit always reads back as zero.
// - the completion of a full retrain write goes out before the retrain starts.
// - a sixteen-bit sticky read-write prbs seed resets to all ones.
// - a change of the seed reloads the prbs counter with it and counting restarts there.
// - a width change applies only once retrain is requested, then the outcome is reported.
package phy_link_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [11:0] OFS_LINK_STATUS = 12'h538;
  localparam logic [11:0] OFS_LINK_STATE  = 12'h540;
  localparam logic [11:0] OFS_PRBS_SEED   = 12'h55c;

  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int RESULT_LSB     = 12;
  localparam int UPCFG_BIT      = 16;
  localparam int STATE_LSB      = 0;
  localparam int RETRAIN_BIT    = 31;
  localparam int SEED_LSB       = 0;
  localparam logic [15:0] SEED_RESET  = 16'hffff;
  localparam logic [4:0]  STATE_RESET = 5'h00;

  // width change outcome codes
  localparam logic [1:0] RESULT_IDLE    = 2'h0;
  localparam logic [1:0] RESULT_SUCCESS = 2'h1;
  localparam logic [1:0] RESULT_PARTIAL = 2'h2;
  localparam logic [1:0] RESULT_FAILED  = 2'h3;

  // ****************************************
  // training state codes
  // ****************************************
  localparam logic [4:0] TS_XMIT_EIOS    = 5'h00;
  localparam logic [4:0] TS_DET_QUIET    = 5'h02;
  localparam logic [4:0] TS_DET_ACTIVE   = 5'h03;
  localparam logic [4:0] TS_POL_ACTIVE   = 5'h04;
  localparam logic [4:0] TS_CFG_COMPLETE = 5'h0c;
  localparam logic [4:0] TS_REC_LOCK     = 5'h10;
  localparam logic [4:0] TS_L0           = 5'h14;
  localparam logic [4:0] TS_DISABLED     = 5'h1a;

  // prbs taps, x^16 + x^14 + x^13 + x^11 + 1
  localparam logic [15:0] PRBS_TAPS = 16'hb400;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [11:0] addr;
    logic [3:0]  byte_en;
    logic [31:0] wdata;
  } cfg_req_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] rdata;
  } cfg_cpl_t;

  typedef struct packed {
    logic       valid;
    logic [1:0] code;
  } width_result_t;

  // full retrain sequencer, gray along idle, completion, fire
  typedef enum logic [1:0] {
    RT_IDLE = 2'b00,
    RT_CPL  = 2'b01,
    RT_FIRE = 2'b11
  } retrain_state_t;

endpackage

// File: src/prbs_counter.sv
// sixteen-bit prbs generator that reloads from a seed
// assumes load and step come from logic on the same clock
`timescale 1ns/1ps
module prbs_counter (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        load,
  input  wire logic [15:0] seed,
  input  wire logic        step,
  output logic [15:0]      value
);
  import phy_link_pkg::*;

  logic [15:0] lfsr_r;
  logic [15:0] lfsr_nxt;

  // load beats step so a new seed is never skipped past
  always_comb begin
    lfsr_nxt = lfsr_r;
    if (load) begin
      lfsr_nxt = seed;
    end else if (step) begin
      lfsr_nxt = {lfsr_r[14:0], ^(lfsr_r & PRBS_TAPS)};
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      lfsr_r <= SEED_RESET;
    end else begin
      lfsr_r <= lfsr_nxt;
    end
  end

  assign value = lfsr_r;
endmodule

// File: verif/phy_partner_model.sv
// far side model: phy training state and width change outcome
// assumes the bank's mclk; the bench steers it through go and outcome
`timescale 1ns/1ps
module phy_partner_model
  import phy_link_pkg::*;
(
  input  wire logic                  mclk,
  input  wire logic                  rst,
  input  wire logic                  full_retrain_trigger,
  input  wire logic                  go,
  input  wire logic [4:0]            go_code,
  input  wire logic                  retrain_request,
  input  wire logic [1:0]            outcome,
  output logic [4:0]                 training_state_code,
  output phy_link_pkg::width_result_t width_reconfig_result
);
  logic [1:0] wait_r;
  // a forced retrain wins over steering; an idle outcome sends no report
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      training_state_code   <= TS_XMIT_EIOS;
      width_reconfig_result <= '0;
      wait_r                <= 2'h0;
    end else begin
      if (full_retrain_trigger)
        training_state_code <= TS_DET_QUIET;
      else if (go)
        training_state_code <= go_code;
      wait_r <= retrain_request ? 2'h3 : (wait_r != 2'h0 ? wait_r - 2'h1 : 2'h0);
      width_reconfig_result.valid <= (wait_r == 2'h1) && (outcome != RESULT_IDLE);
      width_reconfig_result.code  <= outcome;
    end
  end
endmodule

// File: verif/phy_link_chk.sv
// port assertions for the phy link register bank
// assumes one clock domain; bound to every instance of the bank
`timescale 1ns/1ps
module phy_link_chk
  import phy_link_pkg::*;
(
  input wire logic                   mclk,
  input wire logic                   rst,
  input wire phy_link_pkg::cfg_req_t cfg_req,
  input wire phy_link_pkg::cfg_cpl_t cfg_cpl,
  input wire logic                   prbs_step,
  input wire logic                   full_retrain_trigger,
  input wire logic [15:0]            prbs_value,
  input wire logic [15:0]            prbs_seed
);
  logic rtw;
  logic rd;
  // retrain bit write and plain read, decoded once
  assign rtw = cfg_req.valid & cfg_req.write & (cfg_req.addr == OFS_LINK_STATE)
               & cfg_req.byte_en[3] & cfg_req.wdata[RETRAIN_BIT];
  assign rd  = cfg_req.valid & !cfg_req.write;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_cpl_latency: assert property (cfg_req.valid |=> cfg_cpl.valid)
    else $error("completion missing");
  a_trigger_cause: assert property (full_retrain_trigger |-> $past(cfg_cpl.valid) && $past(rtw, 2))
    else $error("retrain fired without prior completion");
  a_trigger_fires: assert property (rtw && !$past(rtw) && !$past(rtw, 2) |-> ##2 full_retrain_trigger)
    else $error("retrain write did not fire");
  a_retrain_reads0: assert property (cfg_cpl.valid |-> !cfg_cpl.rdata[31])
    else $error("retrain bit read as one");
  a_status_rsvd: assert property (rd && cfg_req.addr == OFS_LINK_STATUS |=> (cfg_cpl.rdata & 32'hfffecfff) == 32'h0)
    else $error("status reserved bits set");
  a_state_rsvd: assert property (rd && cfg_req.addr == OFS_LINK_STATE |=> cfg_cpl.rdata[31:5] == 27'h0)
    else $error("state reserved bits set");
  a_seed_read: assert property (rd && cfg_req.addr == OFS_PRBS_SEED |=> cfg_cpl.rdata == {16'h0, $past(prbs_seed)})
    else $error("seed readback wrong");
  a_seed_reload: assert property ($changed(prbs_seed) |=> prbs_value == $past(prbs_seed))
    else $error("prbs not reloaded from seed");
  a_prbs_hold: assert property (!prbs_step && !$changed(prbs_seed) |=> $stable(prbs_value))
    else $error("prbs moved without step");
endmodule
bind phy_link_status_regs phy_link_chk u_chk (.mclk(mclk), .rst(rst), .cfg_req(cfg_req),
  .cfg_cpl(cfg_cpl), .prbs_step(prbs_step), .full_retrain_trigger(full_retrain_trigger),
  .prbs_value(prbs_value), .prbs_seed(prbs_seed));

// File: verif/tb.sv
// self-checking bench for the phy link register bank
// assumes the partner model drives training state and width outcome
`timescale 1ns/1ps
module tb;
  import phy_link_pkg::*;
  typedef struct packed {
    logic [4:0] st;
    logic [1:0] res;
    logic       up;
  } row_t;
  logic          mclk, rst, soft_rst, up, rreq, go, step, trig;
  logic [4:0]    go_code, ts;
  logic [1:0]    outcome;
  logic [15:0]   pval, pseed;
  logic [31:0]   q;
  cfg_req_t      req;
  cfg_cpl_t      cpl;
  width_result_t wres;
  int            failures, comparisons;
  row_t          rows [8] = '{'{TS_XMIT_EIOS, 2'h0, 1'b0}, '{TS_DET_QUIET, 2'h1, 1'b1},
    '{TS_DET_ACTIVE, 2'h2, 1'b0}, '{TS_POL_ACTIVE, 2'h3, 1'b1}, '{TS_CFG_COMPLETE, 2'h1, 1'b0},
    '{TS_REC_LOCK, 2'h2, 1'b1}, '{TS_L0, 2'h3, 1'b0}, '{TS_DISABLED, 2'h0, 1'b1}};
  phy_link_status_regs u_dut (.mclk(mclk), .rst(rst), .soft_rst(soft_rst), .cfg_req(req),
    .cfg_cpl(cpl), .training_state_code(ts), .partner_upconfig_capable(up),
    .retrain_request(rreq), .width_reconfig_result(wres), .prbs_step(step),
    .full_retrain_trigger(trig), .prbs_value(pval), .prbs_seed(pseed));
  phy_partner_model u_phy (.mclk(mclk), .rst(rst), .full_retrain_trigger(trig), .go(go),
    .go_code(go_code), .retrain_request(rreq), .outcome(outcome),
    .training_state_code(ts), .width_reconfig_result(wres));
  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one request, completion is due exactly one cycle later
  task automatic xfer(input logic w, input logic [11:0] a, input logic [3:0] be,
                      input logic [31:0] d);
    @(posedge mclk);
    #1;
    req = '{1'b1, w, a, be, d};
    @(posedge mclk);
    #1;
    req.valid = 1'b0;
    q = cpl.rdata;
    chk({31'h0, cpl.valid}, 32'h1);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 4'h0, 32'h0);
    chk(q, exp);
  endtask
  task automatic results;
    if (failures == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    rst      = 1'b1;
    soft_rst = 1'b0;
    up       = 1'b0;
    rreq     = 1'b0;
    go       = 1'b0;
    go_code  = 5'h00;
    outcome  = 2'h0;
    step     = 1'b0;
    req      = '0;
    repeat (10) @(posedge mclk);
    #1 rst = 1'b0;
    // each row: steer state, capability and outcome, then read both status words
    foreach (rows[i]) begin
      @(posedge mclk);
      #1;
      go      = 1'b1;
      go_code = rows[i].st;
      up      = rows[i].up;
      outcome = rows[i].res;
      rreq    = 1'b1;
      @(posedge mclk);
      #1;
      go   = 1'b0;
      rreq = 1'b0;
      repeat (6) @(posedge mclk);
      rd(OFS_LINK_STATE, {27'h0, rows[i].st});
      rd(OFS_LINK_STATUS, {15'h0, rows[i].up, 2'h0, rows[i].res, 12'h0});
    end
    // read-only places ignore writes and keep their value; unmapped places read zero
    xfer(1'b1, OFS_LINK_STATUS, 4'hf, 32'hffffffff);
    rd(OFS_LINK_STATUS, 32'h00010000);
    rd(12'h544, 32'h0);
    // lane 0 alone; the upper half is reserved and dropped
    xfer(1'b1, OFS_PRBS_SEED, 4'h1, 32'habcd1234);
    chk({16'h0, pseed}, 32'h0000ff34);
    @(posedge mclk);
    #1 chk({16'h0, pval}, 32'h0000ff34);
    rd(OFS_PRBS_SEED, 32'h0000ff34);
    step = 1'b1;
    repeat (3) @(posedge mclk);
    #1 step = 1'b0;
    xfer(1'b1, OFS_PRBS_SEED, 4'h3, 32'h000000a5);
    @(posedge mclk);
    #1 chk({16'h0, pval}, 32'h000000a5);
    // one step from the new seed: no tap bit is set, so the feedback bit is zero
    step = 1'b1;
    @(posedge mclk);
    #1 step = 1'b0;
    chk({16'h0, pval}, 32'h0000014a);
    // hot reset keeps the sticky seed
    soft_rst = 1'b1;
    @(posedge mclk);
    #1 soft_rst = 1'b0;
    rd(OFS_PRBS_SEED, 32'h000000a5);
    // full retrain: completion first, trigger the cycle after
    xfer(1'b1, OFS_LINK_STATE, 4'hf, 32'hffffffff);
    chk({31'h0, trig}, 32'h0);
    @(posedge mclk);
    #1 chk({31'h0, trig}, 32'h1);
    repeat (3) @(posedge mclk);
    rd(OFS_LINK_STATE, {27'h0, TS_DET_QUIET});
    // retrain bit is masked by its byte enable
    xfer(1'b1, OFS_LINK_STATE, 4'h7, 32'h80000000);
    @(posedge mclk);
    #1 chk({31'h0, trig}, 32'h0);
    rst = 1'b1;
    @(posedge mclk);
    #1 rst = 1'b0;
    chk({16'h0, pval}, 32'h0000ffff);
    rd(OFS_PRBS_SEED, 32'h0000ffff);
    rd(OFS_LINK_STATE, 32'h0);
    results();
  end
endmodule
